// >>> eir_pkg.sv
// package for the eee indirect status register bank
package eir_pkg;
	localparam logic [2:0] EIR_TBL_EEE = 3'h1;
	localparam logic [3:0] EIR_SEL_GLOBAL = 4'h0;
	localparam logic [3:0] EIR_PORT_FIRST = 4'h1;
	localparam logic [3:0] EIR_PORT_LAST = 4'h3;
	localparam int EIR_NPORTS = 3;
	localparam logic [7:0] EIR_OFS_RSVD_LPI = 8'h36;
	localparam logic [7:0] EIR_OFS_WAKE_THR = 8'h38;
	localparam logic [7:0] EIR_OFS_RSVD_PCS = 8'h3A;
	localparam logic [7:0] EIR_OFS_PORT_EXP = 8'h00;
	localparam logic [15:0] EIR_RST_RSVD_LPI = 16'h0000;
	localparam logic [15:0] EIR_RST_WAKE_THR = 16'h0201;
	localparam logic [15:0] EIR_RST_RSVD_PCS = 16'h0001;
	localparam int EIR_BIT_LOC_ABLE = 6;
	localparam int EIR_BIT_LOC_SEL = 5;
	localparam int EIR_BIT_PD_FAULT = 4;
	localparam int EIR_BIT_LP_NP = 3;
	localparam int EIR_BIT_NP_ABLE = 2;
	localparam int EIR_BIT_PG_RCVD = 1;
	localparam int EIR_BIT_LP_AN = 0;
	localparam logic [15:0] EIR_RST_WAKE_CNT = 16'h0000;
	localparam logic [15:0] EIR_RST_WAKE_TMR = 16'h0000;
	// events from one copper port's auto-negotiation and phy
	typedef struct packed {
		logic pd_fault;
		logic page_rcvd;
		logic lp_np_able;
		logic lp_an_able;
		logic waking;
	} eir_port_ev_t;
	// host access to the direct byte registers
	typedef struct packed {
		logic ctrl_we;
		logic ofs_we;
		logic data_we;
		logic data_re;
		logic [7:0] wdata;
	} eir_host_t;
endpackage

// >>> eir_regs.sv
// eee indirect register bank: globals plus per-port expansion status
// Summary of operation
// RQ1: table 001, nibble 0 selects globals
// RQ2: offset byte picks the indirect byte
// RQ3: selected byte appears at data byte
// RQ4: even offset high byte, odd low
// RQ5: 0x36 reserved read-only, reads 0x0000
// RQ6: 0x38 fixed wake threshold 0x0201
// RQ7: wake longer than threshold bumps error count
// RQ8: 0x3A reserved read-only, reads 0x0001
// RQ9: status bits 15 to 7 reserved
// RQ10: status bit 6 reads one
// RQ11: status bit 5 reads one, register 8h
// RQ12: fault bit latches, clears on read
// RQ13: bit 3 shows partner next-page ability
// RQ14: bit 2 reads one, local next-page
// RQ15: bit 1 latches on page received
// RQ16: bit 0 shows partner autoneg ability
// RQ17: table 001, nibble 1-3 selects port
// RQ18: only copper ports 1 to 3 present
// RQ19: page bit holds until read, set wins
// RQ20: writes to read-only bytes ignored
`timescale 1ns/1ps
module eir_regs
	import eir_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// direct byte registers from host
	input wire eir_host_t host_in,
	output logic [7:0] ctrl_out,
	output logic [7:0] ofs_out,
	output logic [7:0] rdata_out,
	// per copper port events
	input wire eir_port_ev_t [EIR_NPORTS-1:0] port_ev_in,
	output logic [EIR_NPORTS-1:0][15:0] wake_err_cnt_out
);
	logic [7:0] ctrl_ff;
	logic [7:0] ofs_ff;
	logic [7:0] rdata_ff;
	logic [EIR_NPORTS-1:0] pdf_ff;
	logic [EIR_NPORTS-1:0] pgr_ff;

	wire logic tbl_eee = ctrl_ff[7:5] == EIR_TBL_EEE; // RQ1
	wire logic sel_glb = tbl_eee && ctrl_ff[3:0] == EIR_SEL_GLOBAL; // RQ1
	wire logic sel_prt = tbl_eee && ctrl_ff[3:0] >= EIR_PORT_FIRST && ctrl_ff[3:0] <= EIR_PORT_LAST; // RQ17 RQ18
	wire logic [1:0] port_idx = 2'(ctrl_ff[3:0] - EIR_PORT_FIRST);
	wire logic [7:0] word_ofs = {ofs_ff[7:1], 1'b0};
	wire logic hi_byte = ~ofs_ff[0]; // RQ4

	// expansion status word of one port
	function automatic logic [15:0] port_word(input eir_port_ev_t ev, input logic pdf, input logic pgr);
		logic [15:0] w;
		w = 16'h0000; // RQ9
		w[EIR_BIT_LOC_ABLE] = 1'b1; // RQ10
		w[EIR_BIT_LOC_SEL] = 1'b1; // RQ11
		w[EIR_BIT_PD_FAULT] = pdf;
		w[EIR_BIT_LP_NP] = ev.lp_np_able; // RQ13
		w[EIR_BIT_NP_ABLE] = 1'b1; // RQ14
		w[EIR_BIT_PG_RCVD] = pgr;
		w[EIR_BIT_LP_AN] = ev.lp_an_able; // RQ16
		return w;
	endfunction

	logic [15:0] glb_word;
	always_comb begin
		unique case (word_ofs)
			EIR_OFS_RSVD_LPI: glb_word = EIR_RST_RSVD_LPI; // RQ5
			EIR_OFS_WAKE_THR: glb_word = EIR_RST_WAKE_THR; // RQ6
			EIR_OFS_RSVD_PCS: glb_word = EIR_RST_RSVD_PCS; // RQ8
			default: glb_word = 16'h0000;
		endcase
	end

	wire logic [15:0] prt_word = (word_ofs == EIR_OFS_PORT_EXP) ?
		port_word(port_ev_in[port_idx], pdf_ff[port_idx], pgr_ff[port_idx]) : 16'h0000;
	wire logic [15:0] sel_word = sel_glb ? glb_word : (sel_prt ? prt_word : 16'h0000);
	wire logic [7:0] nxt_rdata = hi_byte ? sel_word[15:8] : sel_word[7:0]; // RQ3 RQ4
	// a read of the status low byte clears the latched bits of that port
	wire logic stat_rd = host_in.data_re && sel_prt && word_ofs == EIR_OFS_PORT_EXP && !hi_byte;

	// data writes land only on read-only bytes here and are dropped
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl_ff <= 8'h00;
			ofs_ff <= 8'h00;
			rdata_ff <= 8'h00;
		end else begin
			if (host_in.ctrl_we) ctrl_ff <= host_in.wdata;
			if (host_in.ofs_we) ofs_ff <= host_in.wdata; // RQ2
			rdata_ff <= nxt_rdata; // RQ3 RQ20
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < EIR_NPORTS; gp++) begin : g_port
			logic [15:0] wake_tmr_ff;
			logic [15:0] wake_cnt_ff;
			logic was_waking_ff;
			wire logic clr = stat_rd && port_idx == 2'(gp);
			wire logic late = port_ev_in[gp].waking && wake_tmr_ff == EIR_RST_WAKE_THR;
			wire logic [15:0] nxt_wake_tmr = port_ev_in[gp].waking ?
				((wake_tmr_ff == EIR_RST_WAKE_THR) ? wake_tmr_ff : wake_tmr_ff + 16'h0001) : EIR_RST_WAKE_TMR;
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					pdf_ff[gp] <= 1'b0;
					pgr_ff[gp] <= 1'b0;
					wake_tmr_ff <= EIR_RST_WAKE_TMR;
					wake_cnt_ff <= EIR_RST_WAKE_CNT;
					was_waking_ff <= 1'b0;
				end else begin
					pdf_ff[gp] <= port_ev_in[gp].pd_fault | (pdf_ff[gp] & ~clr); // RQ12
					pgr_ff[gp] <= port_ev_in[gp].page_rcvd | (pgr_ff[gp] & ~clr); // RQ15 RQ19
					wake_tmr_ff <= nxt_wake_tmr;
					was_waking_ff <= late ? 1'b1 : (port_ev_in[gp].waking ? was_waking_ff : 1'b0);
					// one count per wake that overruns the threshold
					if (late && !was_waking_ff) wake_cnt_ff <= wake_cnt_ff + 16'h0001; // RQ7
				end
			end
			assign wake_err_cnt_out[gp] = wake_cnt_ff;

			chk_fault_holds: assert property (@(posedge clk_in) disable iff (srst_in) // RQ12
				pdf_ff[gp] && !clr |=> pdf_ff[gp])
				else $error("fault bit dropped without a read");
			chk_page_set_wins: assert property (@(posedge clk_in) disable iff (srst_in) // RQ19
				port_ev_in[gp].page_rcvd |=> pgr_ff[gp])
				else $error("page received event lost");
			chk_fault_clears: assert property (@(posedge clk_in) disable iff (srst_in) // RQ12
				clr && !port_ev_in[gp].pd_fault |=> !pdf_ff[gp])
				else $error("fault bit not cleared by read");
			chk_page_clears: assert property (@(posedge clk_in) disable iff (srst_in) // RQ19
				clr && !port_ev_in[gp].page_rcvd |=> !pgr_ff[gp])
				else $error("page bit not cleared by read");
			chk_wake_count: assert property (@(posedge clk_in) disable iff (srst_in) // RQ7
				late && !was_waking_ff |=> wake_cnt_ff == $past(wake_cnt_ff) + 16'h0001)
				else $error("wake error count not bumped");
		end
	endgenerate

	assign ctrl_out = ctrl_ff;
	assign ofs_out = ofs_ff;
	assign rdata_out = rdata_ff;

	chk_thr_read: assert property (@(posedge clk_in) disable iff (srst_in) // RQ6
		sel_glb && ofs_ff == EIR_OFS_WAKE_THR && !host_in.ctrl_we && !host_in.ofs_we |=> rdata_out == 8'h02)
		else $error("threshold high byte wrong");
	chk_rsvd_pcs: assert property (@(posedge clk_in) disable iff (srst_in) // RQ8
		sel_glb && ofs_ff == 8'h3B && !host_in.ctrl_we && !host_in.ofs_we |=> rdata_out == 8'h01)
		else $error("reserved word low byte wrong");
	chk_rsvd_lpi: assert property (@(posedge clk_in) disable iff (srst_in) // RQ5
		sel_glb && word_ofs == EIR_OFS_RSVD_LPI |=> rdata_out == 8'h00)
		else $error("reserved word not zero");
	chk_stat_fixed: assert property (@(posedge clk_in) disable iff (srst_in) // RQ14
		sel_prt && ofs_ff == 8'h01 && !host_in.ctrl_we && !host_in.ofs_we |=> rdata_out[6:5] == 2'h3 && rdata_out[2])
		else $error("fixed status bits wrong");
	chk_stat_high: assert property (@(posedge clk_in) disable iff (srst_in) // RQ9
		sel_prt && ofs_ff == 8'h00 |=> rdata_out == 8'h00)
		else $error("reserved status bits set");
	chk_ofs_load: assert property (@(posedge clk_in) disable iff (srst_in) // RQ2
		host_in.ofs_we |=> ofs_out == $past(host_in.wdata))
		else $error("offset byte not loaded");
	chk_port_range: assert property (@(posedge clk_in) disable iff (srst_in) // RQ18
		sel_prt |-> port_idx < 2'h3)
		else $error("port index out of range");
	chk_ctrl_load: assert property (@(posedge clk_in) disable iff (srst_in) // RQ1
		host_in.ctrl_we |=> ctrl_out == $past(host_in.wdata))
		else $error("control byte not loaded");
endmodule

// >>> eir_host_model.sv
// host model writing the direct byte registers of the bank
`timescale 1ns/1ps
module eir_host_model
	import eir_pkg::*;
(
	input wire logic clk_in,
	output eir_host_t host_out
);
	initial host_out = '0;
	// one strobe high for one cycle, then an idle cycle
	task automatic pulse(input logic [3:0] k, input logic [7:0] d);
		@(negedge clk_in);
		host_out = {k, d};
		@(negedge clk_in);
		host_out = '0;
	endtask
	task automatic sel(input logic [7:0] c, input logic [7:0] o);
		pulse(4'h8, c);
		pulse(4'h4, o);
	endtask
endmodule

// >>> testbench.sv
// self-checking bench for the eee indirect register bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module testbench
	import eir_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	eir_host_t host;
	logic [7:0] ctrl, ofs, rdata;
	eir_port_ev_t [EIR_NPORTS-1:0] ev = '0;
	logic [EIR_NPORTS-1:0][15:0] wcnt;
	int n_fail = 0;
	int n_tests = 0;
	always #2 clk = ~clk;
	eir_host_model i_host (.clk_in(clk), .host_out(host));
	eir_regs i_dut (.clk_in(clk), .srst_in(srst), .host_in(host), .ctrl_out(ctrl), .ofs_out(ofs),
		.rdata_out(rdata), .port_ev_in(ev), .wake_err_cnt_out(wcnt));
	task automatic rd(input logic [7:0] c, input logic [7:0] o, input logic [7:0] e);
		i_host.sel(c, o);
		repeat (2) @(negedge clk);
		`CHK("rdata", e, rdata)
	endtask
	task automatic test_globals();
		rd(8'h20, 8'h36, 8'h00);
		rd(8'h20, 8'h37, 8'h00);
		rd(8'h20, 8'h38, 8'h02);
		rd(8'h20, 8'h39, 8'h01);
		rd(8'h20, 8'h3A, 8'h00);
		i_host.pulse(4'h2, 8'hFF);
		rd(8'h20, 8'h3B, 8'h01);
		rd(8'h40, 8'h38, 8'h00);
		$display("test globals done");
	endtask
	task automatic test_ports();
		for (int p = 1; p <= 3; p++) begin
			rd({4'h2, 4'(p)}, 8'h01, 8'h64);
			rd({4'h2, 4'(p)}, 8'h00, 8'h00);
		end
		rd(8'h24, 8'h01, 8'h00);
		@(negedge clk);
		ev[1].lp_np_able = 1'b1;
		ev[1].lp_an_able = 1'b1;
		ev[1].pd_fault = 1'b1;
		ev[1].page_rcvd = 1'b1;
		@(negedge clk);
		ev[1].pd_fault = 1'b0;
		ev[1].page_rcvd = 1'b0;
		rd(8'h21, 8'h01, 8'h64);
		rd(8'h22, 8'h01, 8'h7F);
		`CHK("ctrl", 8'h22, ctrl)
		`CHK("ofs", 8'h01, ofs)
		i_host.pulse(4'h1, 8'h00);
		rd(8'h22, 8'h01, 8'h6D);
		fork
			i_host.pulse(4'h1, 8'h00);
			begin
				@(negedge clk);
				ev[1].page_rcvd = 1'b1;
				@(negedge clk);
				ev[1].page_rcvd = 1'b0;
			end
		join
		rd(8'h22, 8'h01, 8'h6F);
		$display("test ports done");
	endtask
	task automatic test_wake();
		@(negedge clk);
		ev[2].waking = 1'b1;
		repeat (530) @(negedge clk);
		ev[2].waking = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("wake", 16'h0001, wcnt[2])
		ev[2].waking = 1'b1;
		repeat (20) @(negedge clk);
		ev[2].waking = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("wake", 16'h0001, wcnt[2])
		`CHK("wake", 16'h0000, wcnt[0])
		$display("test wake done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		test_globals();
		test_ports();
		test_wake();
		report_and_stop();
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule
